// *** core/spr_map.svh ***
`ifndef SPR_MAP_SVH
`define SPR_MAP_SVH

// Opcode fields of the individual stack and return instructions.
`define SPR_REARM_LO 8'h8d
`define SPR_PUSH_MID 7'h0d
`define SPR_RTN_OP 16'h8c0d
`define SPR_RETC_OP 16'hac0d
`define SPR_RETNC_OP 16'hec0d
`define SPR_RETZ_OP 16'h9c0d
`define SPR_RETNZ_OP 16'hdc0d
`define SPR_RETS_OP 16'hcc0d

// Destination codes that steer flag updates on a pop.
`define SPR_DST_ACC 7'h08
`define SPR_DST_ACC_PTR 7'h28
`define SPR_DST_ACC_CTL 7'h29
`define SPR_DST_STATUS 7'h48
// Destination code that names the instruction pointer.
`define SPR_DST_INSTR_PTR 7'h0c

// Flag positions inside a popped status word.
`define SPR_STATUS_C 0
`define SPR_STATUS_E 1
// Sign bit of a data word.
`define SPR_SIGN_BIT 15

// Reset values and step sizes.
`define SPR_IP_RST 16'h0000
`define SPR_IP_STEP 16'h0001
`define SPR_ZERO_WORD 16'h0000

`endif

// *** core/spr_pkg.sv ***
package spr_pkg;
	// One data word of the core.
	typedef logic [15:0] spr_word_t;
	// Status flags as seen and produced by the block.
	typedef struct packed {
		logic s;
		logic z;
		logic c;
		logic e;
	} spr_flags_t;
	// Flag update request toward the status register.
	typedef struct packed {
		logic upd_sz;
		logic upd_ce;
		spr_flags_t val;
	} spr_flag_upd_t;
	// Register file write of a popped word.
	typedef struct packed {
		logic en;
		logic [6:0] sel;
		spr_word_t data;
	} spr_dst_wr_t;
	// Stack storage write of a pushed word.
	typedef struct packed {
		logic en;
		spr_word_t data;
	} spr_stk_wr_t;
	// Kinds of instruction this block executes.
	typedef enum logic [2:0] {
		SPR_OTHER,
		SPR_POP_REARM,
		SPR_PUSH,
		SPR_RETURN,
		SPR_RETURN_COND
	} spr_kind_t;
endpackage

// *** core/spr_exec.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - Pop-and-rearm copies top word, then decrements pointer.
// RQ2 - Pop-and-rearm clears the interrupt-in-service flag.
// RQ3 - Pop flags: sign/zero for accumulators, carry/equals status.
// RQ4 - Push increments pointer, writes source, flags untouched.
// RQ5 - Return loads pointer from stack, decrements stack pointer.
// RQ6 - Conditional returns test one flag, change none.
// RQ7 - Return-on-carry returns only when carry set.
// RQ8 - Return-on-no-carry returns only when carry clear.
// RQ9 - Return-on-zero returns only when zero set.
// RQ10 - Failed condition advances instruction pointer by one.
// RQ11 - Return-on-nonzero returns only when zero clear.
// RQ12 - Return-on-sign returns only when sign set.
// RQ13 - Failed return keeps stack, completes in one cycle.
`include "spr_map.svh"

module spr_exec
	import spr_pkg::*;
#(
	parameter int STK_W = 4
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Instruction to execute this cycle.
	input wire logic exec_i,
	input wire spr_word_t instr_i,
	// Operands from the register file and stack storage.
	input wire spr_word_t src_data_i,
	input wire spr_word_t stack_top_i,
	input wire spr_flags_t flags_i,
	// Interrupt logic accepting a request.
	input wire logic int_ack_i,
	// Pointer state.
	output logic [STK_W-1:0] stack_pointer_o,
	output spr_word_t instruction_pointer_o,
	output logic interrupt_in_service_flag_o,
	// Writes toward stack storage and register file.
	output logic [STK_W-1:0] stk_addr_o,
	output spr_stk_wr_t stk_wr_o,
	output spr_dst_wr_t dst_wr_o,
	output spr_flag_upd_t flag_upd_o
);

	// Registered state; all outputs come straight from these.
	logic [STK_W-1:0] stack_pointer;
	logic [STK_W-1:0] next_stack_pointer;
	spr_word_t instruction_pointer;
	spr_word_t next_instruction_pointer;
	logic in_service;
	logic next_in_service;
	logic [STK_W-1:0] stk_addr;
	logic [STK_W-1:0] next_stk_addr;
	spr_stk_wr_t stk_wr;
	spr_stk_wr_t next_stk_wr;
	spr_dst_wr_t dst_wr;
	spr_dst_wr_t next_dst_wr;
	spr_flag_upd_t flag_upd;
	spr_flag_upd_t next_flag_upd;

	// Decode results.
	spr_kind_t kind;
	logic cond_ok;
	logic [6:0] dst_sel;

	assign dst_sel = instr_i[14:8];

	// Classify the instruction word.
	// The pop pattern with the pointer code is a different instruction
	// handled elsewhere, so it is kept out of pop-and-rearm here.
	always_comb begin
		kind = SPR_OTHER;
		if (instr_i == `SPR_RTN_OP) begin
			kind = SPR_RETURN;
		end else if (instr_i == `SPR_RETC_OP ||
			instr_i == `SPR_RETNC_OP ||
			instr_i == `SPR_RETZ_OP ||
			instr_i == `SPR_RETNZ_OP ||
			instr_i == `SPR_RETS_OP) begin
			kind = SPR_RETURN_COND;
		end else if (instr_i[15] && instr_i[7:0] == `SPR_REARM_LO &&
			dst_sel != `SPR_DST_INSTR_PTR) begin
			kind = SPR_POP_REARM; // RQ1
		end else if (instr_i[14:8] == `SPR_PUSH_MID) begin
			// The format bit only says where the source comes from.
			kind = SPR_PUSH; // RQ4
		end
	end

	// Evaluate the tested flag of a conditional return.
	always_comb begin
		case (instr_i)
			`SPR_RETC_OP: begin
				cond_ok = flags_i.c; // RQ7
			end
			`SPR_RETNC_OP: begin
				cond_ok = !flags_i.c; // RQ8
			end
			`SPR_RETZ_OP: begin
				cond_ok = flags_i.z; // RQ9
			end
			`SPR_RETNZ_OP: begin
				cond_ok = !flags_i.z; // RQ11
			end
			`SPR_RETS_OP: begin
				cond_ok = flags_i.s; // RQ12
			end
			default: begin
				// Any other word never returns by condition.
				cond_ok = 1'b0;
			end
		endcase
	end

	// Next values of the pointers, the writes and the flags.
	// Write strobes are single-cycle pulses one edge after execution,
	// which costs a cycle of latency but keeps every output registered.
	always_comb begin
		next_stack_pointer = stack_pointer;
		next_instruction_pointer = instruction_pointer;
		next_in_service = in_service;
		next_stk_addr = stk_addr;
		next_stk_wr = '0;
		next_dst_wr = '0;
		next_flag_upd = '0;
		if (exec_i) begin
			// Sequential flow is the default for every instruction.
			next_instruction_pointer = instruction_pointer +
				`SPR_IP_STEP; // RQ10
			case (kind)
				SPR_POP_REARM: begin
					// Copy the top word, then drop it from the stack.
					next_dst_wr.en = 1'b1; // RQ1
					next_dst_wr.sel = dst_sel;
					next_dst_wr.data = stack_top_i;
					next_stack_pointer = stack_pointer - 1'b1; // RQ1
					next_in_service = 1'b0; // RQ2
					// Accumulator targets report sign and zero.
					if (dst_sel == `SPR_DST_ACC ||
						dst_sel == `SPR_DST_ACC_PTR ||
						dst_sel == `SPR_DST_ACC_CTL) begin
						next_flag_upd.upd_sz = 1'b1; // RQ3
						next_flag_upd.val.s =
							stack_top_i[`SPR_SIGN_BIT];
						next_flag_upd.val.z =
							(stack_top_i == `SPR_ZERO_WORD);
					end else if (dst_sel == `SPR_DST_STATUS) begin
						// The status word hands back carry and equals.
						next_flag_upd.upd_ce = 1'b1; // RQ3
						next_flag_upd.val.c =
							stack_top_i[`SPR_STATUS_C];
						next_flag_upd.val.e =
							stack_top_i[`SPR_STATUS_E];
					end
				end
				SPR_PUSH: begin
					// Grow first, then write at the new top.
					next_stack_pointer = stack_pointer + 1'b1; // RQ4
					next_stk_addr = stack_pointer + 1'b1; // RQ4
					next_stk_wr.en = 1'b1;
					next_stk_wr.data = src_data_i;
				end
				SPR_RETURN: begin
					// Unconditional return, flags left alone.
					next_instruction_pointer = stack_top_i; // RQ5
					next_stack_pointer = stack_pointer - 1'b1; // RQ5
				end
				SPR_RETURN_COND: begin
					// A failed test leaves the stack as it was.
					if (cond_ok) begin
						next_instruction_pointer = stack_top_i; // RQ6
						next_stack_pointer =
							stack_pointer - 1'b1; // RQ6
					end
				end
				default: begin
					// Other instructions only step the pointer here.
					next_stack_pointer = stack_pointer;
				end
			endcase
		end
		// An accepted interrupt wins over a clear in the same cycle,
		// so a request that arrives then is never lost.
		if (int_ack_i) begin
			next_in_service = 1'b1;
		end
	end

	// Register all state on every rising edge.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stack_pointer <= '0;
			instruction_pointer <= `SPR_IP_RST;
			in_service <= 1'b0;
			stk_addr <= '0;
			stk_wr <= '0;
			dst_wr <= '0;
			flag_upd <= '0;
		end else begin
			stack_pointer <= next_stack_pointer;
			instruction_pointer <= next_instruction_pointer;
			in_service <= next_in_service;
			stk_addr <= next_stk_addr;
			stk_wr <= next_stk_wr;
			dst_wr <= next_dst_wr;
			flag_upd <= next_flag_upd;
		end
	end

	// Drive the ports from the registers.
	assign stack_pointer_o = stack_pointer;
	assign instruction_pointer_o = instruction_pointer;
	assign interrupt_in_service_flag_o = in_service;
	assign stk_addr_o = stk_addr;
	assign stk_wr_o = stk_wr;
	assign dst_wr_o = dst_wr;
	assign flag_upd_o = flag_upd;

	// Checks on the executed behaviour.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_rearm_copy_dec: assert property ( // RQ1
		exec_i && kind == SPR_POP_REARM |=>
		dst_wr_o.en && dst_wr_o.data == $past(stack_top_i) &&
		stack_pointer_o == $past(stack_pointer_o) - 1'b1
	) else $error("pop-and-rearm did not copy and decrement");

	a_rearm_clear_flag: assert property ( // RQ2
		exec_i && kind == SPR_POP_REARM && !int_ack_i |=>
		!interrupt_in_service_flag_o
	) else $error("in-service flag not cleared");

	a_rearm_sz_flags: assert property ( // RQ3
		exec_i && kind == SPR_POP_REARM && dst_sel == `SPR_DST_ACC |=>
		flag_upd_o.upd_sz && !flag_upd_o.upd_ce &&
		flag_upd_o.val.z == ($past(stack_top_i) == `SPR_ZERO_WORD)
	) else $error("sign and zero not updated on pop");

	a_push_write_top: assert property ( // RQ4
		exec_i && kind == SPR_PUSH |=>
		stk_wr_o.en && stk_wr_o.data == $past(src_data_i) &&
		stk_addr_o == stack_pointer_o &&
		stack_pointer_o == $past(stack_pointer_o) + 1'b1 &&
		flag_upd_o == '0
	) else $error("push did not write at new top");

	a_return_load_ptr: assert property ( // RQ5
		exec_i && kind == SPR_RETURN |=>
		instruction_pointer_o == $past(stack_top_i) &&
		stack_pointer_o == $past(stack_pointer_o) - 1'b1
	) else $error("return did not load pointer");

	a_cond_no_flags: assert property ( // RQ6
		exec_i && kind == SPR_RETURN_COND |=>
		flag_upd_o == '0 && !dst_wr_o.en && !stk_wr_o.en
	) else $error("conditional return touched flags");

	a_return_carry_test: assert property ( // RQ7 RQ8
		exec_i && (instr_i == `SPR_RETC_OP && flags_i.c ||
		instr_i == `SPR_RETNC_OP && !flags_i.c) |=>
		instruction_pointer_o == $past(stack_top_i)
	) else $error("carry return not taken");

	a_return_zero_sign: assert property ( // RQ9 RQ11 RQ12
		exec_i && (instr_i == `SPR_RETZ_OP && flags_i.z ||
		instr_i == `SPR_RETNZ_OP && !flags_i.z ||
		instr_i == `SPR_RETS_OP && flags_i.s) |=>
		instruction_pointer_o == $past(stack_top_i)
	) else $error("zero or sign return not taken");

	a_cond_fail_step: assert property ( // RQ10 RQ13
		exec_i && kind == SPR_RETURN_COND && !cond_ok |=>
		instruction_pointer_o ==
		$past(instruction_pointer_o) + `SPR_IP_STEP &&
		$stable(stack_pointer_o)
	) else $error("failed return did not step");

	// The pointer and its control register report sign and zero too.
	a_rearm_ptr_flags: assert property ( // RQ3
		exec_i && kind == SPR_POP_REARM &&
		(dst_sel == `SPR_DST_ACC_PTR || dst_sel == `SPR_DST_ACC_CTL) |=>
		flag_upd_o.upd_sz && !flag_upd_o.upd_ce &&
		flag_upd_o.val.s == $past(stack_top_i[`SPR_SIGN_BIT])
	) else $error("sign and zero not updated on pointer pop");

	// A popped status word hands back carry and equals only.
	a_rearm_ce_flags: assert property ( // RQ3
		exec_i && kind == SPR_POP_REARM && dst_sel == `SPR_DST_STATUS |=>
		flag_upd_o.upd_ce && !flag_upd_o.upd_sz &&
		flag_upd_o.val.c == $past(stack_top_i[`SPR_STATUS_C]) &&
		flag_upd_o.val.e == $past(stack_top_i[`SPR_STATUS_E])
	) else $error("carry and equals not updated on pop");

	// The plain return writes nothing and leaves the flags alone.
	a_return_quiet: assert property ( // RQ5
		exec_i && kind == SPR_RETURN |=>
		flag_upd_o == '0 && !dst_wr_o.en && !stk_wr_o.en
	) else $error("return touched flags or storage");

	// A failed return leaves the stack contents untouched.
	a_cond_fail_keep: assert property ( // RQ13
		exec_i && kind == SPR_RETURN_COND && !cond_ok |=>
		!stk_wr_o.en && !dst_wr_o.en &&
		stack_pointer_o == $past(stack_pointer_o)
	) else $error("failed return changed the stack");

	// An accepted interrupt always marks the core as in service.
	a_ack_sets_flag: assert property ( // RQ2
		int_ack_i |=> interrupt_in_service_flag_o
	) else $error("in-service flag not set on acknowledge");

endmodule

// *** verif/spr_exec_tb_top.sv ***
`timescale 1ns/1ps
module spr_exec_tb_top;
	import spr_pkg::*;
	// Expected output state after one clock edge.
	typedef struct packed {
		logic [3:0] ptr;
		spr_word_t iptr;
		logic busy;
		logic [3:0] addr;
		spr_stk_wr_t stk;
		spr_dst_wr_t dst;
		spr_flag_upd_t flg;
		logic [5:0] fmask;
	} spr_exp_t;
	// Ceiling well above reset plus all stimulus cycles.
	localparam int LIMIT = 3000;
	logic clk_i = 1'b0;
	logic rst_n_i;
	logic exec_i;
	spr_word_t instr_i;
	spr_word_t src_data_i;
	spr_word_t stack_top_i;
	spr_flags_t flags_i;
	logic int_ack_i;
	logic [3:0] stack_pointer_o;
	spr_word_t instruction_pointer_o;
	logic interrupt_in_service_flag_o;
	logic [3:0] stk_addr_o;
	spr_stk_wr_t stk_wr_o;
	spr_dst_wr_t dst_wr_o;
	spr_flag_upd_t flag_upd_o;
	spr_exp_t q[$];
	spr_exp_t m;
	spr_exp_t x;
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	// Return opcodes; the first one always returns.
	spr_word_t rets [6] = '{16'h8c0d, 16'hac0d, 16'hec0d, 16'h9c0d,
		16'hdc0d, 16'hcc0d};
	// Pop targets: accumulator, pointer, its control, status, plain.
	logic [6:0] dsts [5] = '{7'h08, 7'h28, 7'h29, 7'h48, 7'h05};

	spr_exec #(.STK_W(4)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.exec_i(exec_i), .instr_i(instr_i), .src_data_i(src_data_i),
		.stack_top_i(stack_top_i), .flags_i(flags_i),
		.int_ack_i(int_ack_i), .stack_pointer_o(stack_pointer_o),
		.instruction_pointer_o(instruction_pointer_o),
		.interrupt_in_service_flag_o(interrupt_in_service_flag_o),
		.stk_addr_o(stk_addr_o), .stk_wr_o(stk_wr_o),
		.dst_wr_o(dst_wr_o), .flag_upd_o(flag_upd_o));

	// Clock of 100 ns period.
	always #50 clk_i = ~clk_i;

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Compares one value; four-state equality keeps unknowns visible.
	task automatic chk(string n, logic [23:0] e, logic [23:0] g);
		comparisons++;
		if (e !== g) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Drives one random instruction and notes what it must produce.
	task automatic step();
		int k;
		logic take;
		logic [6:0] dst;
		k = $urandom_range(0, 10);
		exec_i = (k != 10);
		instr_i = 16'(($urandom_range(0, 1) << 15) | 16'h2a55);
		// Low byte 8d is kept off push words so they never look like pops.
		src_data_i = 16'($urandom);
		if (k == 0) instr_i = {1'b1, dsts[$urandom_range(0, 4)], 8'h8d};
		if (k == 1) instr_i = {1'($urandom), 7'h0d, 8'($urandom) & 8'h7f};
		if (k >= 2 && k <= 7) instr_i = rets[k - 2];
		if (k == 8) instr_i = 16'h8c8d;
		stack_top_i = ($urandom_range(0, 7) == 0) ? 16'h0000 : 16'($urandom);
		flags_i = 4'($urandom);
		int_ack_i = ($urandom_range(0, 7) == 0);
		m.stk = '0;
		m.dst = '0;
		m.flg = '0;
		m.fmask = 6'h3f;
		dst = instr_i[14:8];
		take = 1'b0;
		if (exec_i) begin
			// Sequential advance unless a return is taken.
			m.iptr = m.iptr + 16'h0001;
			case (instr_i)
				16'h8c0d: take = 1'b1;
				16'hac0d: take = flags_i.c;
				16'hec0d: take = !flags_i.c;
				16'h9c0d: take = flags_i.z;
				16'hdc0d: take = !flags_i.z;
				16'hcc0d: take = flags_i.s;
				default: take = 1'b0;
			endcase
			if (take) begin
				m.iptr = stack_top_i;
				m.ptr = m.ptr - 4'h1;
			end else if (instr_i[15] && instr_i[7:0] == 8'h8d && dst != 7'h0c) begin
				m.dst = {1'b1, dst, stack_top_i};
				m.ptr = m.ptr - 4'h1;
				m.busy = 1'b0;
				if (dst inside {7'h08, 7'h28, 7'h29}) begin
					// Only sign and zero are defined on this update.
					m.flg = {2'b10, stack_top_i[15], stack_top_i == 16'h0000, 2'b00};
					m.fmask = 6'h3c;
				end else if (dst == 7'h48) begin
					m.flg = {4'b0100, stack_top_i[0], stack_top_i[1]};
					m.fmask = 6'h33;
				end
			end else if (dst == 7'h0d) begin
				m.ptr = m.ptr + 4'h1;
				m.addr = m.ptr;
				m.stk = {1'b1, src_data_i};
			end
		end
		// A new acknowledge wins over the clear of the same cycle.
		if (int_ack_i) m.busy = 1'b1;
		q.push_back(m);
	endtask

	// Watches the outputs one step after each edge and compares notes.
	always @(posedge clk_i) begin
		#1;
		if (q.size() > 0) begin
			x = q.pop_front();
			chk("stack_pointer", 24'(x.ptr), 24'(stack_pointer_o));
			chk("instr_pointer", 24'(x.iptr), 24'(instruction_pointer_o));
			chk("in_service", 24'(x.busy), 24'(interrupt_in_service_flag_o));
			chk("stk_addr", 24'(x.addr), 24'(stk_addr_o));
			chk("stk_wr", 24'(x.stk), 24'(stk_wr_o));
			chk("dst_wr", 24'(x.dst), 24'(dst_wr_o));
			chk("flag_upd", 24'(x.flg & x.fmask), 24'(flag_upd_o & x.fmask));
		end
	end

	// Cuts a hang short.
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == LIMIT) begin
			err_total++;
			wrap_up();
		end
	end

	// Main sequence: reset, then a long run of random instructions.
	initial begin
		void'($urandom(73305));
		rst_n_i = 1'b0;
		exec_i = 1'b0;
		instr_i = 16'h0000;
		src_data_i = 16'h0000;
		stack_top_i = 16'h0000;
		flags_i = 4'h0;
		int_ack_i = 1'b0;
		m = '0;
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (900) begin
			step();
			@(negedge clk_i);
		end
		exec_i = 1'b0;
		int_ack_i = 1'b0;
		repeat (2) @(negedge clk_i);
		wrap_up();
	end
endmodule
